// File: verilog/iot_pkg.sv
// Shared constants and types for the I/O-timer register decode block
package iot_pkg;
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 10;
   localparam int          RAM_AW_DEF   = 6;
   // Address, interrupt pin and flag bit positions
   localparam int          A_TIMER_BIT  = 2;
   localparam int          A_IRQEN_BIT  = 3;
   localparam int          IRQ_PIN_BIT  = 7;
   localparam int          FLAG_BIT     = 7;
   // Port register select on address bits 1..0
   localparam logic [1:0]  SEL_PA_DATA  = 2'h0;
   localparam logic [1:0]  SEL_PA_DIR   = 2'h1;
   localparam logic [1:0]  SEL_PB_DATA  = 2'h2;
   localparam logic [1:0]  SEL_PB_DIR   = 2'h3;
   // Prescale select on address bits 1..0, and last prescaler count for each
   localparam logic [1:0]  PS_DIV_1     = 2'h0;
   localparam logic [1:0]  PS_DIV_8     = 2'h1;
   localparam logic [1:0]  PS_DIV_64    = 2'h2;
   localparam logic [1:0]  PS_DIV_1024  = 2'h3;
   localparam logic [9:0]  PS_LAST_1    = 10'h000;
   localparam logic [9:0]  PS_LAST_8    = 10'h007;
   localparam logic [9:0]  PS_LAST_64   = 10'h03F;
   localparam logic [9:0]  PS_LAST_1024 = 10'h3FF;
   // Reset values
   localparam logic [7:0]  PORT_RST     = 8'h00;
   localparam logic [7:0]  TIMER_RST    = 8'hFF;
   localparam logic [7:0]  RDATA_RST    = 8'h00;
   localparam logic [7:0]  ROM_SEED_DEF = 8'h5A; // Arbitrary fill pattern

   typedef struct packed {
      logic                rom_sel;
      logic                ram_sel;
      logic                io_sel;
      logic                rd;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
   } iot_req_t;

   typedef enum logic [0:0] {
      TS_COUNT   = 1'b0,
      TS_EXPIRED = 1'b1
   } iot_tstate_t;

   function automatic logic [9:0] iot_ps_last(input logic [1:0] sel);
      case (sel)
         PS_DIV_1: iot_ps_last = PS_LAST_1;
         PS_DIV_8: iot_ps_last = PS_LAST_8;
         PS_DIV_64: iot_ps_last = PS_LAST_64;
         default: iot_ps_last = PS_LAST_1024;
      endcase
   endfunction

   // Port read: output lines give the stored bit, input lines the pin
   function automatic logic [7:0] iot_port_read(input logic [7:0] data, input logic [7:0] dir,
                                                input logic [7:0] pin);
      iot_port_read = (data & dir) | (pin & ~dir);
   endfunction
endpackage

// File: verilog/iot_timer.sv
// Interval timer core: prescaled countdown, expiry flag, free run after expiry
`timescale 1ns/10ps
module iot_timer
   import iot_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // Control
   input  wire logic        load,
   input  wire logic [7:0]  load_val,
   input  wire logic [1:0]  load_ps,
   input  wire logic        access,
   // State
   output logic      [7:0]  count,
   output logic             flag
);
   iot_tstate_t st_q, st_d;
   logic [7:0]  cnt_q, cnt_d;
   logic [9:0]  ps_q, ps_d;
   logic [1:0]  sel_q, sel_d;
   logic        flag_q, flag_d;
   logic        tick, event_hit;

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      ps_d   = ps_q;
      sel_d  = sel_q;
      flag_d = flag_q;
      // After expiry every clock is a tick, whatever prescale was loaded
      tick      = (st_q == TS_EXPIRED) || (ps_q == iot_ps_last(sel_q));
      event_hit = (st_q == TS_COUNT) && tick && (cnt_q == 8'h00);
      case (st_q)
         TS_COUNT: begin
            ps_d = tick ? 10'h000 : ps_q + 10'h001;
            if (tick) begin
               cnt_d = cnt_q - 8'h01;
            end
            if (event_hit) begin
               st_d = TS_EXPIRED;
            end
         end
         TS_EXPIRED: begin
            cnt_d = cnt_q - 8'h01;
         end
         default: st_d = TS_COUNT;
      endcase
      if (load) begin
         st_d  = TS_COUNT;
         cnt_d = load_val;
         ps_d  = 10'h000;
         sel_d = load_ps;
      end
      // Access clears the flag, but an event in the same cycle wins
      if (access) begin
         flag_d = 1'b0;
      end
      if (event_hit) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q   <= TS_EXPIRED;
         cnt_q  <= TIMER_RST;
         ps_q   <= 10'h000;
         sel_q  <= PS_DIV_1;
         flag_q <= 1'b0;
      end else if (ce) begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         ps_q   <= ps_d;
         sel_q  <= sel_d;
         flag_q <= flag_d;
      end
   end

   assign count = cnt_q;
   assign flag  = flag_q;
endmodule

// File: verilog/iot_regs.sv
// Register decode for ROM, RAM, two parallel ports and the interval timer
`timescale 1ns/10ps
// Contract
// - Port region, A2 low: A1..A0 pick port A/B data or direction, read/write.
// - Timer write, A2 high: A1..A0 pick prescale 1/8/64/1024; A3 routes interrupt.
// - Each port has eight lines, each separately input or output by software, except port B line 7 while the interrupt is routed.
// - Input lines read the pin level; output lines drive the stored bit, except routed port B line 7, which only pulls low on the flag.
// - Any timer access clears flag, unless the interrupt event hits that cycle.
// - Address bit 2 low selects port registers, high selects the timer.
// - After expiry timer counts each clock; reading gives elapsed two's complement.
module iot_regs
   import iot_pkg::*;
#(
   parameter int          RAM_AW   = RAM_AW_DEF,
   parameter logic [7:0]  ROM_SEED = ROM_SEED_DEF
)(
   // Clock, reset, enable
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic        CE,
   // Processor bus
   input  wire iot_req_t    BUS_REQ,
   output logic      [7:0]  BUS_RDATA,
   // Port A pins
   input  wire logic [7:0]  PORT_A_IN,
   output logic      [7:0]  PORT_A_OUT,
   output logic      [7:0]  PORT_A_OE,
   // Port B pins
   input  wire logic [7:0]  PORT_B_IN,
   output logic      [7:0]  PORT_B_OUT,
   output logic      [7:0]  PORT_B_OE
);
   localparam int RAM_DEPTH = 1 << RAM_AW;

   // Pin synchronisers
   logic [7:0]  pa_meta_q, pa_sync_q, pb_meta_q, pb_sync_q;

   // Port and control registers
   logic [7:0]  port_a_data_q, port_a_data_d;
   logic [7:0]  port_a_direction_q, port_a_direction_d;
   logic [7:0]  port_b_data_q, port_b_data_d;
   logic [7:0]  port_b_direction_q, port_b_direction_d;
   logic        irq_route_q, irq_route_d;
   logic [7:0]  rdata_q, rdata_d;
   logic [7:0]  ram_q [RAM_DEPTH];
   logic [7:0]  ram_d [RAM_DEPTH];

   // Decode
   logic        rd, wr, io_hit, tmr_hit, port_hit;
   logic [1:0]  low_sel;
   logic [RAM_AW-1:0] ram_idx;
   logic        tmr_load, tmr_access;
   logic [7:0]  tmr_count;
   logic        tmr_flag;
   logic        rom_rd;
   logic        ram_hit;
   logic        ram_wr;
   logic        port_wr;
   logic        port_rd;
   logic        tmr_cnt_rd;
   logic        tmr_flg_rd;

   // Constant ROM image, folded from the address
   function automatic logic [7:0] rom_byte(input logic [ADDR_W-1:0] a);
      rom_byte = a[7:0] ^ {a[9:8], a[9:4]} ^ ROM_SEED;
   endfunction

   assign rd         = BUS_REQ.rd;
   assign wr         = ~BUS_REQ.rd;
   assign io_hit     = BUS_REQ.io_sel && !BUS_REQ.rom_sel && !BUS_REQ.ram_sel;
   assign port_hit   = io_hit && !BUS_REQ.addr[A_TIMER_BIT];
   assign tmr_hit    = io_hit && BUS_REQ.addr[A_TIMER_BIT];
   assign low_sel    = BUS_REQ.addr[1:0];
   assign ram_idx    = BUS_REQ.addr[RAM_AW-1:0];
   assign tmr_load   = tmr_hit && wr;
   assign tmr_access = tmr_hit;
   // Priority ROM, then RAM, then I/O: overlapping selects never reach two targets
   assign rom_rd     = BUS_REQ.rom_sel && rd;
   assign ram_hit    = BUS_REQ.ram_sel && !BUS_REQ.rom_sel;
   assign ram_wr     = ram_hit && wr;
   assign port_wr    = port_hit && wr;
   assign port_rd    = port_hit && rd;
   assign tmr_cnt_rd = tmr_hit && rd && !BUS_REQ.addr[0];
   assign tmr_flg_rd = tmr_hit && rd && BUS_REQ.addr[0];

   iot_timer u_timer (
      .clk      (CLK),
      .rst      (SYS_RST),
      .ce       (CE),
      .load     (tmr_load),
      .load_val (BUS_REQ.wdata),
      .load_ps  (low_sel),
      .access   (tmr_access),
      .count    (tmr_count),
      .flag     (tmr_flag)
   );

   // Port and routing registers; only a port write, a timer write or a timer count read moves them
   always_comb begin
      port_a_data_d      = port_a_data_q;
      port_a_direction_d = port_a_direction_q;
      port_b_data_d      = port_b_data_q;
      port_b_direction_d = port_b_direction_q;
      irq_route_d        = irq_route_q;
      if (port_wr) begin
         case (low_sel)
            SEL_PA_DATA: port_a_data_d      = BUS_REQ.wdata;
            SEL_PA_DIR:  port_a_direction_d = BUS_REQ.wdata;
            SEL_PB_DATA: port_b_data_d      = BUS_REQ.wdata;
            SEL_PB_DIR:  port_b_direction_d = BUS_REQ.wdata;
            default:     port_a_data_d      = port_a_data_q;
         endcase
      end
      // Every timer write sets the routing from A3; a count read sets it from A3 too
      if (tmr_load) begin
         irq_route_d = BUS_REQ.addr[A_IRQEN_BIT];
      end else if (tmr_cnt_rd) begin
         irq_route_d = BUS_REQ.addr[A_IRQEN_BIT];
      end
   end

   // Reset leaves every line an input, so nothing is driven until software asks
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         port_a_data_q      <= PORT_RST;
         port_a_direction_q <= PORT_RST;
         port_b_data_q      <= PORT_RST;
         port_b_direction_q <= PORT_RST;
         irq_route_q        <= 1'b0;
      end else if (CE) begin
         port_a_data_q      <= port_a_data_d;
         port_a_direction_q <= port_a_direction_d;
         port_b_data_q      <= port_b_data_d;
         port_b_direction_q <= port_b_direction_d;
         irq_route_q        <= irq_route_d;
      end
   end

   always_comb begin
      ram_d = ram_q;
      if (ram_wr) begin
         ram_d[ram_idx] = BUS_REQ.wdata;
      end
   end

   // Clearing every byte costs reset wiring but keeps early reads defined
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         for (int i = 0; i < RAM_DEPTH; i++) begin
            ram_q[i] <= 8'h00;
         end
      end else if (CE) begin
         ram_q <= ram_d;
      end
   end

   // Two stages before any logic reads a pin level
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pa_meta_q <= PORT_RST;
         pa_sync_q <= PORT_RST;
         pb_meta_q <= PORT_RST;
         pb_sync_q <= PORT_RST;
      end else if (CE) begin
         pa_meta_q <= PORT_A_IN;
         pa_sync_q <= pa_meta_q;
         pb_meta_q <= PORT_B_IN;
         pb_sync_q <= pb_meta_q;
      end
   end

   // Read data moves only on a read, so it stands until the next one
   always_comb begin
      rdata_d = rdata_q;
      if (rom_rd) begin
         rdata_d = rom_byte(BUS_REQ.addr);
      end else if (ram_hit && rd) begin
         rdata_d = ram_q[ram_idx];
      end else if (port_rd) begin
         case (low_sel)
            SEL_PA_DATA: rdata_d = iot_port_read(port_a_data_q, port_a_direction_q, pa_sync_q);
            SEL_PA_DIR:  rdata_d = port_a_direction_q;
            SEL_PB_DATA: rdata_d = iot_port_read(port_b_data_q, port_b_direction_q, pb_sync_q);
            SEL_PB_DIR:  rdata_d = port_b_direction_q;
            default:     rdata_d = rdata_q;
         endcase
      end else if (tmr_cnt_rd) begin
         rdata_d = tmr_count;
      end else if (tmr_flg_rd) begin
         rdata_d           = 8'h00;
         rdata_d[FLAG_BIT] = tmr_flag;
      end
   end

   // Registered so the bus sees a flop rather than the decode mux
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rdata_q <= RDATA_RST;
      end else if (CE) begin
         rdata_q <= rdata_d;
      end
   end

   // Pins: direction bit 1 drives the line
   always_comb begin
      PORT_A_OUT = port_a_data_q;
      PORT_A_OE  = port_a_direction_q;
      PORT_B_OUT = port_b_data_q;
      PORT_B_OE  = port_b_direction_q;
      // Routed interrupt pulls the top port B line low, open-drain style
      if (irq_route_q) begin
         PORT_B_OUT[IRQ_PIN_BIT] = 1'b0;
         PORT_B_OE[IRQ_PIN_BIT]  = tmr_flag;
      end
   end

   assign BUS_RDATA = rdata_q;
endmodule

// File: tb/iot_regs_assertions.sv
// Bound checker watching the register decode ports
`timescale 1ns/10ps
module iot_regs_chk
   import iot_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic        CE,
   // Processor bus
   input  wire iot_req_t    BUS_REQ,
   input  wire logic [7:0]  BUS_RDATA,
   // Port pins
   input  wire logic [7:0]  PORT_A_OUT,
   input  wire logic [7:0]  PORT_A_OE,
   input  wire logic [7:0]  PORT_B_OUT,
   input  wire logic [7:0]  PORT_B_OE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // Overlapping selects are refused, so only a lone I/O select counts
   wire       io = CE && BUS_REQ.io_sel && !BUS_REQ.rom_sel && !BUS_REQ.ram_sel;
   wire       wr = io && !BUS_REQ.rd;
   wire       rd = io && BUS_REQ.rd;
   wire [2:0] a  = BUS_REQ.addr[2:0];
   wire [7:0] wd = BUS_REQ.wdata;
   dir_a_wr_a: assert property (wr && a == 3'h1 |=> PORT_A_OE == $past(wd))
      else $error("port A direction write lost");
   dat_a_wr_a: assert property (wr && a == 3'h0 |=> PORT_A_OUT == $past(wd))
      else $error("port A data write lost");
   // Bit 7 of port B is shared with the timer pin, so only 6..0 are tied
   dir_b_wr_a: assert property (wr && a == 3'h3 |=> PORT_B_OE[6:0] == $past(wd[6:0]))
      else $error("port B direction write lost");
   dat_b_wr_a: assert property (wr && a == 3'h2 |=> PORT_B_OUT[6:0] == $past(wd[6:0]))
      else $error("port B data write lost");
   dir_rd_a: assert property (rd && a == 3'h1 |=> BUS_RDATA == PORT_A_OE)
      else $error("port A direction read wrong");
   out_rd_a: assert property (rd && a == 3'h0 |=> (BUS_RDATA & PORT_A_OE) == (PORT_A_OUT & PORT_A_OE))
      else $error("output line read wrong");
   tmr_keep_a: assert property (wr && a[2] |=> $stable(PORT_A_OUT) && $stable(PORT_A_OE))
      else $error("timer write touched a port");
   route_on_a: assert property (wr && a[2] && BUS_REQ.addr[3] |=> !PORT_B_OUT[7])
      else $error("routed pin not released low");
   flag_rd_a: assert property (rd && a[2] && a[0] |=> BUS_RDATA[6:0] == 7'h00)
      else $error("flag read carries more than the flag");
endmodule
bind iot_regs iot_regs_chk u_chk (.CLK, .SYS_RST, .CE, .BUS_REQ, .BUS_RDATA, .PORT_A_OUT,
   .PORT_A_OE, .PORT_B_OUT, .PORT_B_OE);

// File: tb/iot_pins.sv
// Peripheral side model: driven lines show the port, released lines the outside level
`timescale 1ns/10ps
module iot_pins (
   // From the port
   input  wire logic [7:0]  out,
   input  wire logic [7:0]  oe,
   // Outside source, standing for pull-ups and sensors
   input  wire logic [7:0]  ext,
   output logic      [7:0]  pin
);
   // A released line never keeps the port's last value
   assign pin = (out & oe) | (ext & ~oe);
endmodule

// File: tb/tb.sv
// Self-checking bench for the register decode
`timescale 1ns/10ps
module tb import iot_pkg::*;;
   logic       CLK, SYS_RST, ce;
   iot_req_t   req;
   logic [7:0] rdata, a_out, a_oe, b_out, b_oe, a_in, b_in, ext_a, ext_b, rv, c;
   int         failures, n_compared, cyc, t;
   int         pv [4] = '{1, 8, 64, 1024};
   iot_regs DUT (.CLK(CLK), .SYS_RST(SYS_RST), .CE(ce), .BUS_REQ(req), .BUS_RDATA(rdata),
      .PORT_A_IN(a_in), .PORT_A_OUT(a_out), .PORT_A_OE(a_oe), .PORT_B_IN(b_in),
      .PORT_B_OUT(b_out), .PORT_B_OE(b_oe));
   iot_pins PA (.out(a_out), .oe(a_oe), .ext(ext_a), .pin(a_in));
   iot_pins PB (.out(b_out), .oe(b_oe), .ext(ext_b), .pin(b_in));
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // Longest test is the 1024 prescale, about 4100 cycles
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         close_out;
      end
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   // One access held for exactly one clock, read data taken after its edge
   // Select s is {rom, ram, io}; the I/O region unless told otherwise
   task automatic bus(input logic r, input logic [9:0] a, input logic [7:0] d = 8'h00,
                      input logic [2:0] s = 3'h1);
      @(negedge CLK);
      req = '{s[2], s[1], s[0], r, a, d};
      @(negedge CLK);
      req = '0;
      rv = rdata;
   endtask
   task automatic close_out;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      req = '0;
      ce = 1'b1;
      ext_a = 8'h3C;
      ext_b = 8'hC3;
      SYS_RST = 1'b1;
      repeat (20) @(posedge CLK);
      @(negedge CLK);
      SYS_RST = 1'b0;
      bus(1, 10'h001); chk("dir A", 8'h00, rv);
      bus(1, 10'h003); chk("dir B", 8'h00, rv);
      bus(1, 10'h000); chk("pins A", 8'h3C, rv);
      bus(0, 10'h001, 8'hF0);
      bus(0, 10'h00B, 8'h0F);
      bus(0, 10'h000, 8'hA5);
      bus(0, 10'h002, 8'h5A);
      bus(1, 10'h000); chk("port A", 8'hAC, rv);
      bus(1, 10'h002); chk("port B", 8'hCA, rv);
      bus(1, 10'h00B); chk("dir B", 8'h0F, rv);
      chk("oe A", 8'hF0, a_oe);
      chk("lines B", 8'h0A, b_in & 8'h0F);
      ext_a = 8'h53;
      repeat (2) @(negedge CLK);
      bus(1, 10'h000); chk("port A", 8'hA3, rv);
      for (int p = 0; p < 4; p++) begin
         bus(0, {8'h03, p[1:0]}, 8'h03);
         t = 0;
         while (b_oe[7] !== 1'b1 && t < 5000) begin
            @(negedge CLK);
            t++;
         end
         chk("expiry", 8'h01, {7'h0, t >= 3 * pv[p] && t <= 4 * pv[p] + 3});
         bus(1, 10'h00D); chk("flag", 8'h80, rv & 8'h80);
         bus(1, 10'h00D); chk("flag", 8'h00, rv & 8'h80);
         chk("irq pin", 8'h00, {7'h0, b_oe[7]});
         bus(1, 10'h00C);
         c = rv;
         bus(1, 10'h00C); chk("free run", c - 8'h02, rv);
      end
      // Clock enable low for five edges: the free-running count must not move
      bus(1, 10'h00C);
      c = rv;
      ce = 1'b0;
      repeat (5) @(negedge CLK);
      ce = 1'b1;
      bus(1, 10'h00C); chk("ce hold", c - 8'h02, rv);
      bus(0, 10'h00C, 8'h04);
      bus(1, 10'h004);
      repeat (12) @(negedge CLK);
      chk("irq pin", 8'h00, {7'h0, b_oe[7]});
      bus(1, 10'h005); chk("flag", 8'h80, rv & 8'h80);
      bus(0, 10'h004, 8'h02);
      repeat (8) @(negedge CLK);
      chk("irq off", 8'h00, {7'h0, b_oe[7]});
      bus(1, 10'h005); chk("flag", 8'h80, rv);
      bus(1, 10'h001); chk("dir A", 8'hF0, rv);
      bus(1, 10'h000); chk("port A", 8'hA3, rv);
      bus(0, 10'h000, 8'h3E, 3'h2);
      bus(1, 10'h000); chk("port A", 8'hA3, rv);
      bus(1, 10'h000, 8'h00, 3'h2); chk("ram", 8'h3E, rv);
      SYS_RST = 1'b1;
      repeat (2) @(negedge CLK);
      SYS_RST = 1'b0;
      bus(1, 10'h001); chk("dir A rst", 8'h00, rv);
      bus(1, 10'h000); chk("pins A rst", 8'h53, rv);
      close_out;
   end
endmodule
